/* abs_out_pkg.sv */
// Purpose: Shared constants and types for the absolute position output block.
// Assumes: 25 MHz clock; pulses-per-revolution setting between 16 and 262144.
// Notes:   Position counts are quadrature edges, four per output pulse.
`default_nettype none
package abs_out_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_HZ             = 25_000_000;
    localparam int CLK_KHZ            = CLK_HZ / 1000;
    localparam int SENSOR_WAIT_MS     = 100;
    localparam int SENSOR_WAIT_CYCLES = CLK_KHZ * SENSOR_WAIT_MS;
    localparam int SETTLE_MS          = 400;
    localparam int SETTLE_CYCLES      = CLK_KHZ * SETTLE_MS;
    localparam int BAUD_BPS           = 9600;
    localparam int BIT_CYCLES         = CLK_HZ / BAUD_BPS;
    localparam int EDGE_GAP_CYCLES    = 2;
    // ==========================================================
    // Pulse generation
    localparam int INIT_RATE_FACTOR   = 680;
    localparam int EDGES_PER_PULSE    = 4;
    localparam int BRACKET_LOG_MIN    = 14;
    localparam int BRACKET_LOG_MAX    = 18;
    localparam int ORIGIN_EDGES       = 2;
    localparam int FIFO_DEPTH         = 4;
    // ==========================================================
    // Widths
    localparam int PPR_W = 19;
    localparam int POS_W = 21;
    localparam int REV_W = 16;
    localparam int TMR_W = 24;
    localparam int ACC_W = 34;
    // ==========================================================
    // Serial frame
    localparam int           FRAME_CHARS = 8;
    localparam int           FRAME_BITS  = 10;
    localparam int           DIGITS      = 5;
    localparam logic [6:0]   CHAR_P      = 7'h50;
    localparam logic [6:0]   CHAR_PLUS   = 7'h2B;
    localparam logic [6:0]   CHAR_MINUS  = 7'h2D;
    localparam logic [6:0]   CHAR_ZERO   = 7'h30;
    localparam logic [6:0]   CHAR_CR     = 7'h0D;
    localparam logic [4:0][15:0] DEC_WEIGHT =
        {16'h0001, 16'h000A, 16'h0064, 16'h03E8, 16'h2710};
    localparam logic [REV_W-1:0] LIMIT_DEFAULT = 16'hFFFF;
    // ==========================================================
    // Origin alignment and quadrature
    localparam logic [1:0] ALIGN_A_RISE = 2'h0;
    localparam logic [1:0] ALIGN_A_FALL = 2'h1;
    localparam logic [1:0] ALIGN_B_RISE = 2'h2;
    localparam logic [1:0] ALIGN_B_FALL = 2'h3;
    localparam logic [1:0] PHASE_MARK   = 2'h3;

    typedef enum logic [2:0] {
        SEQ_IDLE   = 3'h0,
        SEQ_WAIT   = 3'h1,
        SEQ_SERIAL = 3'h3,
        SEQ_INIT   = 3'h2,
        SEQ_NORMAL = 3'h6
    } seq_t;

    typedef struct packed {
        logic fwd;
    } step_t;

    typedef struct packed {
        seq_t                  seq;
        logic [1:0]            sync_on;
        logic [1:0]            sync_pwr;
        logic                  on_d;
        logic [1:0]            phase;
        logic                  a;
        logic                  b;
        logic                  c;
        logic                  last_fwd;
        logic [1:0]            c_edges;
        logic                  c_armed;
        logic [POS_W-1:0]      pos;
        logic [REV_W-1:0]      rev;
        logic [POS_W-1:0]      target;
        logic [POS_W-1:0]      emitted;
        logic [ACC_W-1:0]      acc;
        logic [TMR_W-1:0]      tmr;
        logic [15:0]           mag;
        logic [2:0]            dig_idx;
        logic [4:0][3:0]       digits;
        logic                  neg;
        logic [FRAME_BITS-1:0] sh;
        logic [3:0]            bitn;
        logic [2:0]            chr;
        logic [11:0]           baud;
        logic [1:0]            gap;
        logic                  pwr_en;
    } state_t;

    localparam state_t STATE_RESET = '0;
endpackage : abs_out_pkg
`default_nettype wire

/* absolute_position_output.sv */
// Purpose: Encoder emulation output that reports absolute position after sensor-on.
// Assumes: Steps arrive already divided; configuration inputs are static.
// Notes:   Steps arrive as quadrature edges, four per output pulse.
// Function
// [RULE1] A carries frame then pulses; B pulses.
// [RULE2] Origin pulse as wide as phase A.
// [RULE3] Origin pulse aligned to selected A/B edge.
// [RULE4] Host ignores origin pulse during reception.
// [RULE5] Host starts with the sensor-on command.
// [RULE6] Frame follows after 100 ms wait.
// [RULE7] Normal pulses resume 400 ms after frame.
// [RULE8] Forward rotation: phase B leads phase A.
// [RULE9] Initial pulses equal origin-to-position count.
// [RULE10] Initial rate 680*setting/bracket kpps.
// [RULE11] Host forms absolute value from parts.
// [RULE12] Host negates revolutions in reverse mode.
// [RULE13] Revolution factor is the divided pulse count.
// [RULE14] 9600 baud, start, even parity, stop.
// [RULE15] Frame: P, sign, five digits, CR.
// [RULE16] Zero revolutions send plus sign zeros.
// [RULE17] Revolutions wrap at the configured limits.
// [RULE18] Revolutions count from setup reference.
// [RULE19] Motor power held off during sequence.
// [RULE20] Serial line idles at mark level.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Step FIFO
module step_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic        push;
    logic        pop;

    assign in_ready  = st.cnt != (AW+1)'(DEPTH);
    assign out_valid = st.cnt != '0;
    assign out_data  = st.mem[st.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr         = AW'(st.wr + 1'b1);
        end
        if (pop) begin
            next_st.rd = AW'(st.rd + 1'b1);
        end
        next_st.cnt = (AW+1)'(st.cnt + {AW'(0), push} - {AW'(0), pop});
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : step_fifo

// ==========================================================
// Absolute position output
module absolute_position_output #(
    parameter int WAIT_CYCLES   = abs_out_pkg::SENSOR_WAIT_CYCLES,
    parameter int SETTLE_CYCLES = abs_out_pkg::SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // Host command pins
    input  wire logic                    sensor_on_command,
    input  wire logic                    motor_power_on_command,
    // Configuration
    input  wire logic [18:0]             output_pulses_per_rev,
    input  wire logic [1:0]              origin_align_select,
    input  wire logic [15:0]             multiturn_limit,
    input  wire logic                    setup_clear,
    // Divided incremental steps
    input  wire logic                    step_valid,
    output logic                         step_ready,
    input  wire abs_out_pkg::step_t      step_data,
    // Encoder emulation pins
    output logic                         phase_a_out,
    output logic                         phase_b_out,
    output logic                         origin_pulse_out,
    // Status
    output logic                         motor_power_enable,
    output abs_out_pkg::seq_t            seq_state
);
    localparam int BIT_CYC = abs_out_pkg::BIT_CYCLES;
    localparam int ACC_W   = abs_out_pkg::ACC_W;
    localparam int POS_W   = abs_out_pkg::POS_W;
    localparam int TMR_W   = abs_out_pkg::TMR_W;

    abs_out_pkg::state_t st;
    abs_out_pkg::state_t nx;
    abs_out_pkg::step_t  q_data;
    logic                q_valid;
    logic                q_ready;
    logic                step_en;
    logic                step_fwd;
    logic                on_rise;
    logic [1:0]          np;
    logic                hit;
    logic [POS_W-1:0]    four_r;
    logic [ACC_W-1:0]    thr;
    logic [ACC_W-1:0]    inc;
    logic                signed_mode;

    // Smallest power-of-two bracket holding the pulse setting.
    function automatic int bracket_log(input logic [18:0] ppr);
        int lg;
        lg = abs_out_pkg::BRACKET_LOG_MAX;
        for (int k = abs_out_pkg::BRACKET_LOG_MAX; k >= abs_out_pkg::BRACKET_LOG_MIN; k--) begin
            if (32'(ppr) <= (32'h1 << k)) begin
                lg = k;
            end
        end
        return lg;
    endfunction : bracket_log

    function automatic logic [9:0] frame_word(input logic [2:0] idx, input logic neg,
                                              input logic [4:0][3:0] d);
        logic [6:0] ch;
        case (idx)
            3'h0:    ch = abs_out_pkg::CHAR_P;
            3'h1:    ch = neg ? abs_out_pkg::CHAR_MINUS : abs_out_pkg::CHAR_PLUS; // RULE16
            3'h7:    ch = abs_out_pkg::CHAR_CR;
            default: ch = abs_out_pkg::CHAR_ZERO + {3'h0, d[3'(idx - 3'h2)]};
        endcase
        return {1'b1, ^ch, ch, 1'b0}; // RULE14
    endfunction : frame_word

    step_fifo #(
        .WIDTH ($bits(abs_out_pkg::step_t)),
        .DEPTH (abs_out_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (step_valid),
        .in_ready  (step_ready),
        .in_data   (step_data),
        .out_valid (q_valid),
        .out_ready (q_ready),
        .out_data  (q_data)
    );

    assign four_r      = {2'h0, output_pulses_per_rev} << 2; // RULE13
    assign thr         = ACC_W'(abs_out_pkg::CLK_KHZ) << bracket_log(output_pulses_per_rev);
    assign inc         = ACC_W'(output_pulses_per_rev)
                       * ACC_W'(abs_out_pkg::INIT_RATE_FACTOR * abs_out_pkg::EDGES_PER_PULSE);
    assign signed_mode = multiturn_limit == abs_out_pkg::LIMIT_DEFAULT;
    assign on_rise     = st.sync_on[1] && !st.on_d;

    always_comb begin
        nx       = st;
        step_en  = 1'b0;
        step_fwd = 1'b1;
        q_ready  = 1'b0;
        np       = st.phase;
        hit      = 1'b0;
        nx.sync_on  = {st.sync_on[0], sensor_on_command};
        nx.sync_pwr = {st.sync_pwr[0], motor_power_on_command};
        nx.on_d     = st.sync_on[1];
        if (st.gap != 2'h0) begin
            nx.gap = st.gap - 2'h1;
        end
        if (st.tmr != '0) begin
            nx.tmr = st.tmr - 1'b1;
        end
        case (st.seq)
            abs_out_pkg::SEQ_IDLE, abs_out_pkg::SEQ_NORMAL: begin
                if (st.seq == abs_out_pkg::SEQ_IDLE && on_rise) begin
                    nx.seq     = abs_out_pkg::SEQ_WAIT;
                    nx.tmr     = TMR_W'(WAIT_CYCLES - 1); // RULE6
                    nx.phase   = abs_out_pkg::PHASE_MARK;
                    nx.neg     = signed_mode && st.rev[15];
                    nx.mag     = nx.neg ? 16'(-st.rev) : st.rev;
                    nx.dig_idx = 3'h0;
                    nx.digits  = '0;
                    nx.target  = st.pos; // RULE9
                end else if (q_valid && st.gap == 2'h0) begin
                    q_ready  = 1'b1;
                    step_en  = 1'b1;
                    step_fwd = q_data.fwd;
                    nx.gap   = 2'(abs_out_pkg::EDGE_GAP_CYCLES - 1);
                end
            end
            abs_out_pkg::SEQ_WAIT: begin
                if (st.dig_idx < 3'(abs_out_pkg::DIGITS)) begin
                    if (st.mag >= abs_out_pkg::DEC_WEIGHT[st.dig_idx]) begin
                        nx.mag = st.mag - abs_out_pkg::DEC_WEIGHT[st.dig_idx];
                        nx.digits[st.dig_idx] = st.digits[st.dig_idx] + 4'h1;
                    end else begin
                        nx.dig_idx = st.dig_idx + 3'h1;
                    end
                end
                if (st.tmr == '0) begin
                    nx.seq  = abs_out_pkg::SEQ_SERIAL;
                    nx.chr  = 3'h0;
                    nx.bitn = 4'h0;
                    nx.baud = 12'(BIT_CYC - 1);
                    nx.sh   = frame_word(3'h0, st.neg, st.digits); // RULE15
                end
            end
            abs_out_pkg::SEQ_SERIAL: begin
                if (st.baud != 12'h0) begin
                    nx.baud = st.baud - 12'h1;
                end else begin
                    nx.baud = 12'(BIT_CYC - 1); // RULE14
                    if (st.bitn == 4'(abs_out_pkg::FRAME_BITS - 1)) begin
                        nx.bitn = 4'h0;
                        if (st.chr == 3'(abs_out_pkg::FRAME_CHARS - 1)) begin
                            nx.seq     = abs_out_pkg::SEQ_INIT;
                            nx.tmr     = TMR_W'(SETTLE_CYCLES - 1); // RULE7
                            nx.emitted = '0;
                            nx.acc     = '0;
                        end else begin
                            nx.chr = st.chr + 3'h1;
                            nx.sh  = frame_word(nx.chr, st.neg, st.digits); // RULE15
                        end
                    end else begin
                        nx.bitn = st.bitn + 4'h1;
                        nx.sh   = {1'b1, st.sh[9:1]};
                    end
                end
            end
            abs_out_pkg::SEQ_INIT: begin
                nx.acc = st.acc + inc; // RULE10
                if (nx.acc >= thr) begin
                    nx.acc = nx.acc - thr;
                    if (st.emitted != st.target) begin
                        step_en    = 1'b1; // RULE9
                        nx.emitted = st.emitted + 1'b1;
                    end
                end
                if (st.tmr == '0 && st.emitted == st.target) begin
                    nx.seq = abs_out_pkg::SEQ_NORMAL; // RULE7
                end
            end
            default: begin
                nx.seq = abs_out_pkg::SEQ_IDLE;
            end
        endcase
        if (step_en) begin
            np          = step_fwd ? st.phase + 2'h1 : st.phase - 2'h1; // RULE8
            nx.phase    = np;
            nx.last_fwd = step_fwd;
            case (origin_align_select)
                abs_out_pkg::ALIGN_A_RISE: hit = !st.phase[1] && np[1];
                abs_out_pkg::ALIGN_A_FALL: hit = st.phase[1] && !np[1];
                abs_out_pkg::ALIGN_B_RISE: hit = !(^st.phase) && (^np);
                default:                   hit = (^st.phase) && !(^np);
            endcase
            if (st.c) begin
                nx.c_edges = st.c_edges + 2'h1;
                if (st.c_edges == 2'(abs_out_pkg::ORIGIN_EDGES - 1)) begin
                    nx.c = 1'b0; // RULE2
                end
            end else if (st.c_armed && hit) begin
                nx.c       = 1'b1; // RULE3
                nx.c_edges = 2'h0;
                nx.c_armed = 1'b0;
            end
            if (st.seq != abs_out_pkg::SEQ_INIT) begin
                if (step_fwd && st.pos == POS_W'(four_r - 1'b1)) begin
                    nx.pos     = '0;
                    nx.c_armed = 1'b1;
                    nx.rev     = (!signed_mode && st.rev == multiturn_limit) ? '0
                               : st.rev + 16'h0001; // RULE17
                end else if (!step_fwd && st.pos == '0) begin
                    nx.pos     = POS_W'(four_r - 1'b1);
                    nx.c_armed = 1'b1;
                    nx.rev     = (!signed_mode && st.rev == '0) ? multiturn_limit
                               : st.rev - 16'h0001; // RULE17
                end else begin
                    nx.pos = step_fwd ? st.pos + 1'b1 : st.pos - 1'b1;
                end
            end
        end
        if (setup_clear) begin
            nx.pos = '0; // RULE18
            nx.rev = '0;
        end
        if (!st.sync_on[1]) begin
            nx.seq = abs_out_pkg::SEQ_IDLE;
        end
        case (nx.seq)
            abs_out_pkg::SEQ_WAIT: begin
                nx.a = 1'b1; // RULE20
                nx.b = 1'b0;
            end
            abs_out_pkg::SEQ_SERIAL: begin
                nx.a = nx.sh[0]; // RULE1
                nx.b = 1'b0;
            end
            default: begin
                nx.a = nx.phase[1]; // RULE1
                nx.b = ^nx.phase;
            end
        endcase
        nx.pwr_en = nx.seq == abs_out_pkg::SEQ_NORMAL && st.sync_pwr[1]; // RULE19
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= abs_out_pkg::STATE_RESET;
        end else begin
            st <= nx;
        end
    end

    assign phase_a_out        = st.a;
    assign phase_b_out        = st.b;
    assign origin_pulse_out   = st.c;
    assign motor_power_enable = st.pwr_en;
    assign seq_state          = st.seq;

    // ==========================================================
    // Checks
    logic [15:0]      low_run;
    logic [TMR_W-1:0] seq_age;
    logic [3:0]       chars_seen;
    logic [POS_W-1:0] init_edges;
    logic [1:0]       c_seen;
    logic             quad_moved;
    logic             prev_a;
    logic             prev_b;

    assign quad_moved = (phase_a_out != prev_a) || (phase_b_out != prev_b);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_run    <= '0;
            seq_age    <= '0;
            chars_seen <= '0;
            init_edges <= '0;
            c_seen     <= '0;
            prev_a     <= 1'b0;
            prev_b     <= 1'b0;
        end else begin
            prev_a     <= phase_a_out;
            prev_b     <= phase_b_out;
            low_run    <= phase_a_out ? 16'h0 : low_run + 16'h1;
            seq_age    <= (nx.seq != st.seq) ? '0 : seq_age + 1'b1;
            chars_seen <= (st.seq != abs_out_pkg::SEQ_SERIAL) ? 4'h0
                        : chars_seen + {3'h0, $fell(phase_a_out) && st.bitn == 4'h0};
            init_edges <= (st.seq == abs_out_pkg::SEQ_SERIAL) ? '0
                        : init_edges + {20'h0, st.seq == abs_out_pkg::SEQ_INIT && quad_moved};
            c_seen     <= !origin_pulse_out ? 2'h0 : c_seen + {1'b0, quad_moved};
        end
    end

    sequence s_serial_end;
        st.seq == abs_out_pkg::SEQ_SERIAL ##1 st.seq == abs_out_pkg::SEQ_INIT;
    endsequence
    sequence s_init_end;
        st.seq == abs_out_pkg::SEQ_INIT ##1 st.seq == abs_out_pkg::SEQ_NORMAL;
    endsequence

    a_wait_length: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        (st.seq == abs_out_pkg::SEQ_WAIT && nx.seq == abs_out_pkg::SEQ_SERIAL)
        |-> seq_age == TMR_W'(WAIT_CYCLES - 1)) else $error("wait before frame wrong");
    a_settle_min: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
        s_init_end |-> $past(seq_age) >= TMR_W'(SETTLE_CYCLES - 1))
        else $error("normal pulses resumed too early");
    a_init_count: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
        s_init_end |-> init_edges == st.target) else $error("initial pulse count wrong");
    a_frame_chars: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
        s_serial_end |-> chars_seen == 4'(abs_out_pkg::FRAME_CHARS))
        else $error("frame character count wrong");
    a_bit_width: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
        ($rose(phase_a_out) && st.seq == abs_out_pkg::SEQ_SERIAL)
        |-> (32'(low_run) % BIT_CYC) == 0) else $error("serial bit width wrong");
    a_mark_idle: assert property (@(posedge clk) disable iff (!rst_n) // RULE20
        st.seq == abs_out_pkg::SEQ_WAIT |-> phase_a_out) else $error("line not at mark");
    a_b_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
        st.seq inside {abs_out_pkg::SEQ_WAIT, abs_out_pkg::SEQ_SERIAL} |-> !phase_b_out)
        else $error("phase B moved during frame");
    a_power_held: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
        st.seq inside {abs_out_pkg::SEQ_WAIT, abs_out_pkg::SEQ_SERIAL} |=> !motor_power_enable)
        else $error("motor power during sequence");
    a_b_leads: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        (st.last_fwd && st.seq == abs_out_pkg::SEQ_NORMAL && quad_moved)
        |-> ($rose(phase_a_out) && phase_b_out) || ($rose(phase_b_out) && !phase_a_out)
            || ($fell(phase_a_out) && !phase_b_out) || ($fell(phase_b_out) && phase_a_out))
        else $error("forward order wrong");
    a_origin_align: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        $rose(origin_pulse_out) |-> quad_moved
        && (origin_align_select != abs_out_pkg::ALIGN_A_RISE || $rose(phase_a_out))
        && (origin_align_select != abs_out_pkg::ALIGN_A_FALL || $fell(phase_a_out))
        && (origin_align_select != abs_out_pkg::ALIGN_B_RISE || $rose(phase_b_out))
        && (origin_align_select != abs_out_pkg::ALIGN_B_FALL || $fell(phase_b_out)))
        else $error("origin pulse misaligned");
    a_origin_width: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        $fell(origin_pulse_out) |-> quad_moved && c_seen == 2'(abs_out_pkg::ORIGIN_EDGES))
        else $error("origin pulse width wrong");
endmodule : absolute_position_output

`default_nettype wire

/* host_model.sv */
// Purpose: Host side model with quadrature counter and serial receiver.
// Assumes: Frame bits are sampled in the middle of each bit.
// Notes:   The counter never uses the origin pulse.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host model
module host_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Encoder pins and host control
    input  wire logic       a,
    input  wire logic       b,
    input  wire logic       c,
    input  wire logic       clr,
    input  wire logic       listen,
    // Results
    output int              cnt,
    output int              c_rises,
    output int              n_chars,
    output logic            frame_ok,
    output logic [7:0][6:0] chars
);
    logic       pa, pb, pc;
    logic [9:0] sh;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {pa, pb, pc} <= 3'h0;
            cnt <= 0;
            c_rises <= 0;
        end else begin
            {pa, pb, pc} <= {a, b, c};
            c_rises <= c_rises + int'(c && !pc);
            if (clr) begin
                cnt <= 0;
            end else if (a != pa || b != pb) begin
                cnt <= cnt + (((b != pb) ? (b != a) : (a == b)) ? 1 : -1);
            end
        end
    end
    initial begin
        n_chars = 0;
        frame_ok = 1'b1;
        chars = '0;
        forever begin
            @(negedge a iff listen);
            repeat (abs_out_pkg::BIT_CYCLES / 2) @(posedge clk);
            for (int i = 0; i < 10; i++) begin
                sh[i] = a;
                if (i < 9) repeat (abs_out_pkg::BIT_CYCLES) @(posedge clk);
            end
            chars[n_chars[2:0]] = sh[7:1];
            frame_ok &= !sh[0] && sh[9] && !(^sh[8:1]);
            n_chars++;
        end
    end
endmodule : host_model
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench for the absolute position output block.
// Assumes: Shortened wait and settle counts; origin on phase A rise, then B rise.
// Notes:   Inputs change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch at %0t: %h vs %h", $time, (g), (e)); end end
// ==========================================================
// Bench
module tb_top;
    localparam int WAIT_N = 50;
    localparam int SETTLE_N = 200;
    int n_mismatch = 0, checks_done = 0, cnt, c_rises, n_chars, n, c;
    logic clk = 1'b0, rst_n = 1'b0, sensor_on_command = 1'b0, motor_power_on_command = 1'b0;
    logic setup_clear = 1'b0, step_valid = 1'b0, clr = 1'b0, listen = 1'b0, frame_ok;
    logic step_ready, phase_a_out, phase_b_out, origin_pulse_out, motor_power_enable;
    logic [7:0][6:0] chars;
    logic [1:0] align = 2'h0;
    abs_out_pkg::step_t step_data = '{fwd: 1'b1};
    abs_out_pkg::seq_t seq_state;
    absolute_position_output #(.WAIT_CYCLES(WAIT_N), .SETTLE_CYCLES(SETTLE_N)) dut_u (
        .clk, .rst_n, .sensor_on_command, .motor_power_on_command,
        .output_pulses_per_rev(19'h00010), .origin_align_select(align),
        .multiturn_limit(16'hFFFF), .setup_clear, .step_valid, .step_ready, .step_data,
        .phase_a_out, .phase_b_out, .origin_pulse_out, .motor_power_enable, .seq_state);
    host_model host_u (.clk, .rst_n, .a(phase_a_out), .b(phase_b_out),
        .c(origin_pulse_out), .clr, .listen, .cnt, .c_rises, .n_chars, .frame_ok, .chars);
    initial forever #20 clk = ~clk;
    task automatic push(input int want, output int taken);
        taken = 0;
        step_valid = 1'b1;
        for (int t = 0; t < 4 * want && taken < want; t++) begin
            taken += int'(step_ready === 1'b1);
            @(negedge clk);
        end
        step_valid = 1'b0;
    endtask : push
    task automatic wait_seq(input abs_out_pkg::seq_t s, input int lim, output int k);
        for (k = 0; seq_state !== s && k < lim; k++) @(negedge clk);
    endtask : wait_seq
    task automatic t_reset;
        `CHECK(seq_state, abs_out_pkg::SEQ_IDLE)
        `CHECK({phase_a_out, phase_b_out, origin_pulse_out, motor_power_enable}, 4'h0)
        `CHECK(step_ready, 1'b1)
    endtask : t_reset
    task automatic t_turn;
        setup_clear = 1'b1;
        @(negedge clk);
        setup_clear = 1'b0;
        push(68, n);
        repeat (20) @(negedge clk);
        `CHECK(cnt, 68)
        `CHECK(c_rises, 1)
    endtask : t_turn
    task automatic t_frame;
        motor_power_on_command = 1'b1;
        sensor_on_command = 1'b1;
        wait_seq(abs_out_pkg::SEQ_WAIT, 10, c);
        listen = 1'b1;
        clr = 1'b1;
        `CHECK(phase_a_out, 1'b1)
        `CHECK(motor_power_enable, 1'b0)
        @(negedge clk);
        clr = 1'b0;
        wait_seq(abs_out_pkg::SEQ_SERIAL, 100, c);
        `CHECK(c + 1, WAIT_N)
        push(8, n);
        `CHECK(n, abs_out_pkg::FIFO_DEPTH)
        `CHECK(step_ready, 1'b0)
        `CHECK(motor_power_enable, 1'b0)
        for (int k = 0; n_chars < 8 && k < 250000; k++) @(negedge clk);
        listen = 1'b0;
        `CHECK(frame_ok, 1'b1)
        `CHECK(chars, {abs_out_pkg::CHAR_CR, abs_out_pkg::CHAR_ZERO + 7'h01, {4{abs_out_pkg::CHAR_ZERO}},
            abs_out_pkg::CHAR_PLUS, abs_out_pkg::CHAR_P})
        wait_seq(abs_out_pkg::SEQ_INIT, 3000, c);
        wait_seq(abs_out_pkg::SEQ_NORMAL, 40000, c);
        `CHECK(c inside {[37000:38500]}, 1'b1)
        `CHECK(cnt, 4)
        `CHECK(int'(chars[6] - abs_out_pkg::CHAR_ZERO) * 16 * 4 + cnt, 68)
        `CHECK(-int'(chars[6] - abs_out_pkg::CHAR_ZERO) * 16 * 4 + cnt, -60)
        repeat (4) @(negedge clk);
        `CHECK(motor_power_enable, 1'b1)
        repeat (30) @(negedge clk);
        `CHECK(cnt, 8)
        sensor_on_command = 1'b0;
        repeat (5) @(negedge clk);
        `CHECK({seq_state, motor_power_enable}, {abs_out_pkg::SEQ_IDLE, 1'b0})
    endtask : t_frame
    task automatic t_align;
        align = abs_out_pkg::ALIGN_B_RISE;
        push(64, n);
        repeat (20) @(negedge clk);
        `CHECK(c_rises, 2)
        `CHECK(cnt, 72)
    endtask : t_align
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_reset();
        t_turn();
        t_frame();
        t_align();
        results();
    end
    initial begin
        #12_000_000;
        n_mismatch++;
        results();
    end
endmodule : tb_top
`default_nettype wire
